/* File: hw/sppc_regs.sv */
`timescale 1ns/100ps
`include "sppc_map.svh"

module sppc_regs #(
  parameter int TICK_CYCLES = `SPPC_TICK_PERIOD_NS / `SPPC_CLK_PERIOD_NS,
  parameter int NUM_TIMED = 9,
  parameter int NUM_PROT = 15
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port, addressed by register number
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_err_o,
  // motor state and measured conditions
  input wire sppc_pkg::sppc_motor_status_t motor_status_i,
  input wire logic [15:0] active_fault_code_i,
  input wire logic starting_i,
  input wire logic running_i,
  input wire logic [NUM_PROT-1:0] cond_i,
  input wire logic manual_clear_i,
  // protection results and output functions
  output logic [NUM_PROT-1:0] prot_fault_o,
  output logic [NUM_PROT-1:0] prot_warn_o,
  output logic [1:0] relay_out_o,
  output logic [1:0] net_out_o,
  output logic fault_clear_o,
  output logic [15:0] attempts_o
);

  // configuration store, one word per register number
  logic [15:0] cfg_reg [0:`SPPC_REG_COUNT-1];

  // register number to store index
  wire logic in_range = (reg_addr_i >= `SPPC_REG_FIRST) && (reg_addr_i <= `SPPC_REG_LAST);
  wire logic [15:0] idx_full = reg_addr_i - `SPPC_REG_FIRST;
  wire logic [5:0] idx = idx_full[5:0];

  // read a register by its number
  function automatic logic [15:0] cfg_at(input logic [15:0] num);
    logic [15:0] off;
    off = num - `SPPC_REG_FIRST;
    return cfg_reg[off[5:0]];
  endfunction : cfg_at

  // value check per register; the custom fault codes hold free 16-bit codes, unlisted numbers are durations
  function automatic logic value_ok(input logic [15:0] num, input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    if (num <= `SPPC_NET_OUTPUT2_SELECT) begin
      ok = (v <= `SPPC_SELECT_MAX);
    end else if (num <= `SPPC_CUSTOM_FAULT_CODE_C) begin
      ok = 1'b1;
    end else if (num == `SPPC_FAULT_CLEAR_POLICY) begin
      ok = (v <= `SPPC_POLICY_MAX);
    end else if (num == `SPPC_AUTO_CLEAR_DELAY) begin
      ok = (v >= `SPPC_DELAY_MIN) && (v <= `SPPC_DELAY_MAX);
    end else if (num == `SPPC_AUTO_CLEAR_ATTEMPT_LIMIT) begin
      ok = (v <= `SPPC_ATTEMPT_MAX);
    end else if (num == `SPPC_OVERLOAD_IN_START_ENABLE) begin
      ok = (v <= `SPPC_FLAG_MAX);
    end else if (num == `SPPC_THERMAL_OVERLOAD_ENABLE ||
      num == `SPPC_PHASE_ORDER_ENABLE ||
      num == `SPPC_LOW_CURRENT_ENABLE ||
      num == `SPPC_JAM_ENABLE ||
      num == `SPPC_STALL_ENABLE ||
      num == `SPPC_MISSING_PHASE_ENABLE ||
      num == `SPPC_CURRENT_UNBALANCE_ENABLE ||
      num == `SPPC_LOW_VOLTAGE_ENABLE ||
      num == `SPPC_HIGH_VOLTAGE_ENABLE ||
      num == `SPPC_MAINS_FREQ_ENABLE ||
      num == `SPPC_MEAN_POWER_ENABLE ||
      num == `SPPC_AUX_INPUT_ENABLE ||
      num == `SPPC_TEMP_PROBE_ENABLE ||
      num == `SPPC_THYRISTOR_MISFIRE_ENABLE) begin
      ok = (v <= `SPPC_MODE_MAX);
    end else if (num == `SPPC_LOW_CURRENT_LEVEL ||
      num == `SPPC_MAINS_FREQ_DEVIATION ||
      num == `SPPC_AUX_INPUT_LOW_LEVEL ||
      num == `SPPC_AUX_INPUT_HIGH_LEVEL) begin
      ok = (v <= `SPPC_PCT_MAX);
    end else if (num == `SPPC_MISSING_PHASE_LEVEL ||
      num == `SPPC_CURRENT_UNBALANCE_LEVEL ||
      num == `SPPC_VOLTAGE_UNBALANCE_LEVEL) begin
      ok = (v >= `SPPC_PCT_MIN) && (v <= `SPPC_PCT_MAX);
    end else if (num == `SPPC_LOW_VOLTAGE_LEVEL) begin
      ok = (v >= `SPPC_PCT_MIN) && (v <= `SPPC_LOW_VOLT_MAX);
    end else if (num == `SPPC_HIGH_VOLTAGE_LEVEL) begin
      ok = (v >= `SPPC_HIGH_VOLT_MIN) && (v <= `SPPC_HIGH_VOLT_MAX);
    end else if (num == `SPPC_MEAN_POWER_LOW_LEVEL) begin
      ok = (v <= `SPPC_POWER_LOW_MAX);
    end else if (num == `SPPC_MEAN_POWER_HIGH_LEVEL) begin
      ok = (v <= `SPPC_POWER_HIGH_MAX);
    end else begin
      // every remaining number is a duration in tenths of a second
      ok = (v >= `SPPC_DUR_MIN) && (v <= `SPPC_DUR_MAX);
    end
    return ok;
  endfunction : value_ok

  // reset value: smallest legal value, so the store never holds an illegal word
  function automatic logic [15:0] reset_val(input int i);
    logic [15:0] num;
    num = 16'(i) + `SPPC_REG_FIRST;
    if (value_ok(num, 16'h0000)) begin
      return 16'h0000;
    end else if (num == `SPPC_HIGH_VOLTAGE_LEVEL) begin
      return `SPPC_HIGH_VOLT_MIN;
    end else begin
      return 16'h0001;
    end
  endfunction : reset_val

  // write decode: values arrive as unsigned words, out-of-range ones bounce
  wire logic wr_ok = reg_wr_i && in_range && value_ok(reg_addr_i, reg_wdata_i);
  wire logic acc_err = (reg_wr_i && !wr_ok) || (reg_rd_i && !in_range);

  // configuration store; a rejected write leaves the word untouched
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `SPPC_REG_COUNT; i++) begin
        cfg_reg[i] <= reset_val(i);
      end
    end else if (wr_ok) begin
      cfg_reg[idx] <= reg_wdata_i;
    end
  end

  // read data and access answer, one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o <= 1'b0;
      reg_err_o <= 1'b0;
    end else begin
      reg_rdata_o <= (reg_rd_i && in_range) ? cfg_reg[idx] : 16'h0000;
      reg_ack_o <= reg_wr_i || reg_rd_i;
      reg_err_o <= acc_err;
    end
  end

  // 0.1 s tick shared by every timer; a long count, so it is a parameter
  logic [31:0] tick_cnt_reg;
  wire logic tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end
  end

  // enable and duration numbers of the timed protections, in cond_i order;
  // voltage imbalance has no enable of its own and follows current imbalance
  localparam logic [15:0] TIMED_EN [0:8] = '{
    `SPPC_LOW_CURRENT_ENABLE,
    `SPPC_MISSING_PHASE_ENABLE,
    `SPPC_CURRENT_UNBALANCE_ENABLE,
    `SPPC_CURRENT_UNBALANCE_ENABLE,
    `SPPC_LOW_VOLTAGE_ENABLE,
    `SPPC_HIGH_VOLTAGE_ENABLE,
    `SPPC_MAINS_FREQ_ENABLE,
    `SPPC_MEAN_POWER_ENABLE,
    `SPPC_AUX_INPUT_ENABLE};
  localparam logic [15:0] TIMED_DUR [0:8] = '{
    `SPPC_LOW_CURRENT_DURATION,
    `SPPC_MISSING_PHASE_DURATION,
    `SPPC_CURRENT_UNBALANCE_DURATION,
    `SPPC_VOLTAGE_UNBALANCE_DURATION,
    `SPPC_LOW_VOLTAGE_DURATION,
    `SPPC_HIGH_VOLTAGE_DURATION,
    `SPPC_MAINS_FREQ_DURATION,
    `SPPC_MEAN_POWER_DURATION,
    `SPPC_AUX_INPUT_DURATION};
  // enable numbers of the instantaneous protections, in cond_i order
  localparam logic [15:0] FAST_EN [0:5] = '{
    `SPPC_THERMAL_OVERLOAD_ENABLE,
    `SPPC_PHASE_ORDER_ENABLE,
    `SPPC_JAM_ENABLE,
    `SPPC_STALL_ENABLE,
    `SPPC_TEMP_PROBE_ENABLE,
    `SPPC_THYRISTOR_MISFIRE_ENABLE};

  logic [NUM_PROT-1:0] hit; // condition has qualified
  logic [1:0] mode [0:NUM_PROT-1]; // enable field per protection

  // persistence timers: count ticks while the condition holds
  for (genvar k = 0; k < NUM_TIMED; k++) begin : g_timed
    logic [15:0] dwell_reg;
    wire logic [15:0] dur = cfg_at(TIMED_DUR[k]);
    // undervoltage only counts while the motor runs
    wire logic live = cond_i[k] && ((k != 4) || running_i);
    assign mode[k] = 2'(cfg_at(TIMED_EN[k]));
    assign hit[k] = live && (dwell_reg >= dur);

    // any break in the condition restarts the wait
    always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
        dwell_reg <= 16'h0000;
      end else if (!live) begin
        dwell_reg <= 16'h0000;
      end else if (tick && dwell_reg < dur) begin
        dwell_reg <= dwell_reg + 16'h0001;
      end
    end
  end

  // instantaneous protections; overload masked during start unless allowed
  wire logic ovl_start_ok = 1'(cfg_at(`SPPC_OVERLOAD_IN_START_ENABLE));
  for (genvar k = NUM_TIMED; k < NUM_PROT; k++) begin : g_fast
    assign mode[k] = 2'(cfg_at(FAST_EN[k-NUM_TIMED]));
    if (k == NUM_TIMED) begin : g_ovl
      assign hit[k] = cond_i[k] && (!starting_i || ovl_start_ok);
    end else begin : g_plain
      assign hit[k] = cond_i[k];
    end
  end

  // split qualified conditions into trip and warning by enable coding
  logic [NUM_PROT-1:0] fault_next;
  logic [NUM_PROT-1:0] warn_next;
  always_comb begin
    for (int k = 0; k < NUM_PROT; k++) begin
      fault_next[k] = hit[k] && (mode[k] == sppc_pkg::PM_FAULT);
      warn_next[k] = hit[k] && (mode[k] == sppc_pkg::PM_WARN);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prot_fault_o <= '0;
      prot_warn_o <= '0;
    end else begin
      prot_fault_o <= fault_next;
      prot_warn_o <= warn_next;
    end
  end

  // custom code match: only meaningful while a fault is active
  wire logic code_hit = motor_status_i.faulted &&
    ((active_fault_code_i == cfg_at(`SPPC_CUSTOM_FAULT_CODE_A)) ||
     (active_fault_code_i == cfg_at(`SPPC_CUSTOM_FAULT_CODE_B)) ||
     (active_fault_code_i == cfg_at(`SPPC_CUSTOM_FAULT_CODE_C)));

  // output function per selector code
  function automatic logic sel_eval(input logic [15:0] code,
                                    input sppc_pkg::sppc_motor_status_t st,
                                    input logic ch);
    logic r;
    case (code[3:0])
      4'h1: r = st.faulted;
      4'h2: r = !st.faulted;
      4'h3: r = st.bypass;
      4'h4: r = !st.bypass;
      4'h5: r = st.energized;
      4'h6: r = !st.energized;
      4'h7: r = st.warning;
      4'h8: r = !st.warning;
      4'h9: r = ch;
      4'hA: r = !ch;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : sel_eval

  // the four selectable outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      relay_out_o <= 2'b00;
      net_out_o <= 2'b00;
    end else begin
      relay_out_o[0] <= sel_eval(cfg_at(`SPPC_RELAY_OUTPUT1_SELECT), motor_status_i, code_hit);
      relay_out_o[1] <= sel_eval(cfg_at(`SPPC_RELAY_OUTPUT2_SELECT), motor_status_i, code_hit);
      net_out_o[0] <= sel_eval(cfg_at(`SPPC_NET_OUTPUT1_SELECT), motor_status_i, code_hit);
      net_out_o[1] <= sel_eval(cfg_at(`SPPC_NET_OUTPUT2_SELECT), motor_status_i, code_hit);
    end
  end

  // fault clear sequencing
  sppc_pkg::sppc_auto_state_t ar_reg;
  logic [15:0] ar_wait_reg; // ticks waited in the auto delay
  logic por_pending_reg; // set in reset, cleared at the first edge after it, while the policy still reads FC_MANUAL
  wire sppc_pkg::sppc_clear_policy_t policy =
    sppc_pkg::sppc_clear_policy_t'(2'(cfg_at(`SPPC_FAULT_CLEAR_POLICY)));
  wire logic [15:0] ar_delay = cfg_at(`SPPC_AUTO_CLEAR_DELAY);
  wire logic [15:0] ar_limit = cfg_at(`SPPC_AUTO_CLEAR_ATTEMPT_LIMIT);
  wire logic fault_now = motor_status_i.faulted;
  wire logic ar_go = (policy == sppc_pkg::FC_AUTO) && fault_now && (attempts_o < ar_limit);
  wire logic ar_fire = (ar_reg == sppc_pkg::AR_WAIT) && (ar_wait_reg >= ar_delay);
  wire logic man_fire = (policy == sppc_pkg::FC_MANUAL) && manual_clear_i;
  wire logic por_fire = (policy == sppc_pkg::FC_POWER_ON) && por_pending_reg;

  // automatic clear: wait the delay, clear, then hold until the fault drops
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ar_reg <= sppc_pkg::AR_IDLE;
      ar_wait_reg <= 16'h0000;
    end else begin
      case (ar_reg)
        sppc_pkg::AR_IDLE: begin
          ar_wait_reg <= 16'h0000;
          if (ar_go) begin
            ar_reg <= sppc_pkg::AR_WAIT;
          end
        end
        sppc_pkg::AR_WAIT: begin
          if (!fault_now || policy != sppc_pkg::FC_AUTO) begin
            ar_reg <= sppc_pkg::AR_IDLE;
          end else if (ar_fire) begin
            ar_reg <= sppc_pkg::AR_HOLD;
          end else if (tick) begin
            ar_wait_reg <= ar_wait_reg + 16'h0001;
          end
        end
        sppc_pkg::AR_HOLD: begin
          // a clear that did not take must not retrigger at once
          if (!fault_now) begin
            ar_reg <= sppc_pkg::AR_IDLE;
          end
        end
        default: begin
          ar_reg <= sppc_pkg::AR_IDLE;
        end
      endcase
    end
  end

  // attempt count and the clear pulse; a manual clear restarts the count
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      attempts_o <= 16'h0000;
      fault_clear_o <= 1'b0;
      por_pending_reg <= 1'b1;
    end else begin
      fault_clear_o <= ar_fire || man_fire || por_fire;
      por_pending_reg <= 1'b0;
      if (manual_clear_i) begin
        attempts_o <= 16'h0000;
      end else if (ar_fire) begin
        attempts_o <= attempts_o + 16'h0001;
      end
    end
  end

endmodule : sppc_regs

/* File: hw/sppc_map.svh */
`ifndef SPPC_MAP_SVH
`define SPPC_MAP_SVH

// clock period and persistence tick (0.1 s) in nanoseconds
`define SPPC_CLK_PERIOD_NS 40
`define SPPC_TICK_PERIOD_NS 100000000

// register numbers as seen by the network master
`define SPPC_REG_FIRST 16'h0279
`define SPPC_REG_LAST 16'h02A5
`define SPPC_REG_COUNT 45
`define SPPC_RELAY_OUTPUT1_SELECT 16'h0279
`define SPPC_RELAY_OUTPUT2_SELECT 16'h027A
`define SPPC_NET_OUTPUT1_SELECT 16'h027B
`define SPPC_NET_OUTPUT2_SELECT 16'h027C
`define SPPC_CUSTOM_FAULT_CODE_A 16'h027D
`define SPPC_CUSTOM_FAULT_CODE_B 16'h027E
`define SPPC_CUSTOM_FAULT_CODE_C 16'h027F
`define SPPC_FAULT_CLEAR_POLICY 16'h0280
`define SPPC_AUTO_CLEAR_DELAY 16'h0281
`define SPPC_AUTO_CLEAR_ATTEMPT_LIMIT 16'h0282
`define SPPC_THERMAL_OVERLOAD_ENABLE 16'h0283
`define SPPC_OVERLOAD_IN_START_ENABLE 16'h0284
`define SPPC_PHASE_ORDER_ENABLE 16'h0285
`define SPPC_LOW_CURRENT_ENABLE 16'h0286
`define SPPC_LOW_CURRENT_LEVEL 16'h0287
`define SPPC_LOW_CURRENT_DURATION 16'h0288
`define SPPC_JAM_ENABLE 16'h0289
`define SPPC_STALL_ENABLE 16'h028A
`define SPPC_MISSING_PHASE_ENABLE 16'h028B
`define SPPC_MISSING_PHASE_LEVEL 16'h028C
`define SPPC_MISSING_PHASE_DURATION 16'h028D
`define SPPC_CURRENT_UNBALANCE_ENABLE 16'h028E
`define SPPC_CURRENT_UNBALANCE_LEVEL 16'h028F
`define SPPC_CURRENT_UNBALANCE_DURATION 16'h0290
`define SPPC_VOLTAGE_UNBALANCE_LEVEL 16'h0291
`define SPPC_VOLTAGE_UNBALANCE_DURATION 16'h0292
`define SPPC_LOW_VOLTAGE_ENABLE 16'h0293
`define SPPC_LOW_VOLTAGE_LEVEL 16'h0294
`define SPPC_LOW_VOLTAGE_DURATION 16'h0295
`define SPPC_HIGH_VOLTAGE_ENABLE 16'h0296
`define SPPC_HIGH_VOLTAGE_LEVEL 16'h0297
`define SPPC_HIGH_VOLTAGE_DURATION 16'h0298
`define SPPC_MAINS_FREQ_ENABLE 16'h0299
`define SPPC_MAINS_FREQ_DEVIATION 16'h029A
`define SPPC_MAINS_FREQ_DURATION 16'h029B
`define SPPC_MEAN_POWER_ENABLE 16'h029C
`define SPPC_MEAN_POWER_LOW_LEVEL 16'h029D
`define SPPC_MEAN_POWER_HIGH_LEVEL 16'h029E
`define SPPC_MEAN_POWER_DURATION 16'h029F
`define SPPC_AUX_INPUT_ENABLE 16'h02A0
`define SPPC_AUX_INPUT_LOW_LEVEL 16'h02A1
`define SPPC_AUX_INPUT_HIGH_LEVEL 16'h02A2
`define SPPC_AUX_INPUT_DURATION 16'h02A3
`define SPPC_TEMP_PROBE_ENABLE 16'h02A4
`define SPPC_THYRISTOR_MISFIRE_ENABLE 16'h02A5

// value limits
`define SPPC_SELECT_MAX 16'h000A
`define SPPC_POLICY_MAX 16'h0002
`define SPPC_MODE_MAX 16'h0002
`define SPPC_FLAG_MAX 16'h0001
`define SPPC_DELAY_MIN 16'h0001
`define SPPC_DELAY_MAX 16'h1770
`define SPPC_ATTEMPT_MAX 16'h2710
`define SPPC_PCT_MAX 16'h0064
`define SPPC_PCT_MIN 16'h0001
`define SPPC_LOW_VOLT_MAX 16'h0063
`define SPPC_HIGH_VOLT_MIN 16'h0065
`define SPPC_HIGH_VOLT_MAX 16'h0078
`define SPPC_POWER_LOW_MAX 16'h03E8
`define SPPC_POWER_HIGH_MAX 16'h1F40
`define SPPC_DUR_MIN 16'h0001
`define SPPC_DUR_MAX 16'h0258

`endif

/* File: hw/sppc_pkg.sv */
package sppc_pkg;

  // motor state seen by the output selectors
  typedef struct packed {
    logic faulted;
    logic bypass;
    logic energized;
    logic warning;
  } sppc_motor_status_t;

  // protection enable coding: off, trip, warn only
  typedef enum logic [1:0] {
    PM_OFF,
    PM_FAULT,
    PM_WARN
  } sppc_prot_mode_t;

  // fault clear policy coding
  typedef enum logic [1:0] {
    FC_MANUAL,
    FC_AUTO,
    FC_POWER_ON
  } sppc_clear_policy_t;

  // automatic clear sequencer
  typedef enum logic [1:0] {
    AR_IDLE,
    AR_WAIT,
    AR_HOLD
  } sppc_auto_state_t;

endpackage : sppc_pkg

/* File: bench/sppc_regs_sva.sv */
`timescale 1ns/100ps
// port and protection checks, bound to the bank
module sppc_regs_sva #(
  parameter int NUM_PROT = 15
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic reg_err_o,
  // protections and fault clearing
  input wire logic [NUM_PROT-1:0] cond_i,
  input wire logic [NUM_PROT-1:0] prot_fault_o,
  input wire logic [NUM_PROT-1:0] prot_warn_o,
  input wire logic fault_clear_o,
  input wire logic [15:0] attempts_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // any strobe; one outside the window
  wire logic strobe = reg_wr_i | reg_rd_i;
  wire logic unmapped = (reg_addr_i < 16'h0279) || (reg_addr_i > 16'h02A5);

  // selector write with a code above ten
  sequence s_sel_bad;
    reg_wr_i && (reg_addr_i >= 16'h0279) && (reg_addr_i <= 16'h027C)
      && (reg_wdata_i > 16'h000A);
  endsequence
  // write to one register number
  sequence s_wr_at(logic [15:0] a);
    reg_wr_i && (reg_addr_i == a);
  endsequence

  ack_after_strobe_a: assert property (strobe |=> reg_ack_o)
    else $error("no ack after strobe");
  ack_has_cause_a: assert property (reg_ack_o |-> $past(strobe))
    else $error("ack without strobe");
  unmapped_err_a: assert property (strobe && unmapped |=>
    reg_err_o && reg_rdata_o == 16'h0000) else $error("unmapped access taken");
  select_range_a: assert property (s_sel_bad |=> reg_err_o)
    else $error("selector code accepted");
  attempt_range_a: assert property (s_wr_at(16'h0282) |=>
    reg_err_o == ($past(reg_wdata_i) > 16'h2710)) else $error("attempt check wrong");
  delay_range_a: assert property (s_wr_at(16'h0281) |=> reg_err_o ==
    ($past(reg_wdata_i) == 16'h0000 || $past(reg_wdata_i) > 16'h1770))
    else $error("delay check wrong");
  idle_rdata_a: assert property (!reg_ack_o |-> reg_rdata_o == 16'h0000)
    else $error("rdata outside answer");
  mode_exclusive_a: assert property ((prot_fault_o & prot_warn_o) == '0)
    else $error("fault with warning");
  drop_follow_a: assert property (((prot_fault_o | prot_warn_o) & ~$past(cond_i)) == '0)
    else $error("output without condition");
  timed_persist_a: assert property ($rose(prot_fault_o[0]) |->
    $past(cond_i[0], 2) && $past(cond_i[0], 3)) else $error("timed trip too early");
  clear_pulse_a: assert property (fault_clear_o |=> !fault_clear_o)
    else $error("clear pulse too long");
  attempt_step_a: assert property ((attempts_o != $past(attempts_o)) |->
    (attempts_o == 16'h0000) || (fault_clear_o && attempts_o == $past(attempts_o) + 16'h0001))
    else $error("attempt count jumped");
endmodule : sppc_regs_sva

bind sppc_regs sppc_regs_sva #(.NUM_PROT(NUM_PROT)) u_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
  .cond_i(cond_i), .prot_fault_o(prot_fault_o), .prot_warn_o(prot_warn_o),
  .fault_clear_o(fault_clear_o), .attempts_o(attempts_o)
);

/* File: bench/sppc_master_model.sv */
`timescale 1ns/100ps
// network master: one strobed access at a time on the register port
module sppc_master_model (
  // clock
  input wire logic clk_sys_i,
  // register port towards the bank
  output logic [15:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic reg_err_i
);
  // idle bus at time zero
  initial begin
    reg_addr_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // strobe for one cycle, answer taken just after the edge that took it
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                        output logic [15:0] rdata, output logic err);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o = addr;
    reg_wdata_o = data;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // released lines show the inverse, so stale values look wrong
    reg_addr_o = ~addr;
    reg_wdata_o = ~data;
    rdata = reg_rdata_i;
    err = reg_err_i;
  endtask : access
endmodule : sppc_master_model

/* File: bench/sppc_regs_tb.sv */
`timescale 1ns/100ps
module sppc_regs_tb;
  // short tick keeps the tenth-second timers a few clocks long
  localparam int NUM_PROT = 15;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, active_code, attempts;
  logic reg_wr, reg_rd, reg_ack, reg_err, starting, running, manual_clear, fault_clear;
  sppc_pkg::sppc_motor_status_t motor_status;
  logic [NUM_PROT-1:0] cond, prot_fault, prot_warn;
  logic [1:0] relay_out, net_out;
  logic [15:0] shadow [logic [15:0]]; // expected store contents
  int fail_count = 0, cmp_count = 0, cycles = 0, clr_seen = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  sppc_regs #(.TICK_CYCLES(4)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_ack_o(reg_ack),
    .reg_err_o(reg_err), .motor_status_i(motor_status), .active_fault_code_i(active_code),
    .starting_i(starting), .running_i(running), .cond_i(cond), .manual_clear_i(manual_clear),
    .prot_fault_o(prot_fault), .prot_warn_o(prot_warn), .relay_out_o(relay_out),
    .net_out_o(net_out), .fault_clear_o(fault_clear), .attempts_o(attempts)
  );
  sppc_master_model u_master (
    .clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .reg_err_i(reg_err)
  );

  // count clear pulses; cut a hang short
  always @(posedge clk_sys_i) begin
    cycles++;
    if (fault_clear === 1'b1) clr_seen++;
    if (cycles == 5000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // read back against the shadow; unmapped reads zero
  task automatic rchk(input logic [15:0] addr);
    logic [15:0] q;
    logic e;
    u_master.access(1'b0, addr, 16'h0000, q, e);
    check_val(q, shadow.exists(addr) ? shadow[addr] : 16'h0000);
  endtask : rchk

  // write, judge refusal, then read back
  task automatic wchk(input logic [15:0] addr, input logic [15:0] val, input logic bad);
    logic [15:0] q;
    logic e;
    u_master.access(1'b1, addr, val, q, e);
    check_val(16'(e), 16'(bad));
    if (!bad) shadow[addr] = val;
    rchk(addr);
  endtask : wchk

  // let n edges pass, then step off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle

  function automatic logic sel_exp(input int c, input logic [3:0] st, input logic m);
    logic [10:0] f;
    f = {~m, m, ~st[0], st[0], ~st[1], st[1], ~st[2], st[2], ~st[3], st[3], 1'b0};
    return f[c];
  endfunction : sel_exp

  // reset contents: zero, or the smallest legal value
  task automatic reset_vals();
    logic [15:0] ones [14] = '{16'h0281, 16'h0288, 16'h028D, 16'h0290, 16'h0292, 16'h0295,
      16'h0298, 16'h029B, 16'h029F, 16'h02A3, 16'h028C, 16'h028F, 16'h0291, 16'h0294};
    for (int a = 16'h0279; a <= 16'h02A5; a++) shadow[16'(a)] = 16'h0000;
    foreach (ones[i]) shadow[ones[i]] = 16'h0001;
    shadow[16'h0297] = 16'h0065;
    for (int a = 16'h0279; a <= 16'h02A5; a++) rchk(16'(a));
  endtask : reset_vals

  // range edges of each parameter kind and the window
  task automatic range_test();
    wchk(16'h027C, 16'h000B, 1'b1);
    wchk(16'h027F, 16'hFFFF, 1'b0);
    wchk(16'h0280, 16'h0003, 1'b1);
    wchk(16'h0281, 16'h0000, 1'b1);
    wchk(16'h0281, 16'h1770, 1'b0);
    wchk(16'h0281, 16'h1771, 1'b1);
    wchk(16'h0282, 16'h2710, 1'b0);
    wchk(16'h0282, 16'h2711, 1'b1);
    wchk(16'h0283, 16'h0003, 1'b1);
    wchk(16'h0284, 16'h0002, 1'b1);
    wchk(16'h0287, 16'h0065, 1'b1);
    wchk(16'h0288, 16'h0259, 1'b1);
    wchk(16'h028C, 16'h0000, 1'b1);
    wchk(16'h028F, 16'h0064, 1'b0);
    wchk(16'h0291, 16'h0000, 1'b1);
    wchk(16'h0294, 16'h0064, 1'b1);
    wchk(16'h0297, 16'h0064, 1'b1);
    wchk(16'h0297, 16'h0078, 1'b0);
    wchk(16'h029A, 16'h0065, 1'b1);
    wchk(16'h029E, 16'h1F41, 1'b1);
    wchk(16'h02A2, 16'h0065, 1'b1);
    wchk(16'h0278, 16'h0001, 1'b1);
    wchk(16'h02A6, 16'h0001, 1'b1);
  endtask : range_test

  // every selector code in two opposite motor states
  task automatic sel_test();
    logic [3:0] st;
    wchk(16'h027E, 16'h00C3, 1'b0);
    for (int p = 0; p < 2; p++) begin
      st = p ? 4'b0101 : 4'b1010;
      motor_status = st;
      active_code = p ? 16'h0077 : 16'h00C3;
      for (int c = 0; c <= 10; c++) begin
        wchk(16'h0279, 16'(c), 1'b0);
        wchk(16'h027C, 16'(c), 1'b0);
        settle(2);
        check_val(16'(relay_out[0]), 16'(sel_exp(c, st, p == 0)));
        check_val(16'(net_out[1]), 16'(sel_exp(c, st, p == 0)));
      end
    end
    motor_status = 4'b0000;
  endtask : sel_test

  // untimed protections other than overload in every enable mode
  task automatic mode_test();
    logic [15:0] regs [5] = '{16'h0285, 16'h0289, 16'h028A, 16'h02A4, 16'h02A5};
    for (int p = 0; p < 5; p++) begin
      for (int md = 0; md < 3; md++) begin
        wchk(regs[p], 16'(md), 1'b0);
        cond[10+p] = 1'b1;
        settle(2);
        check_val(16'(prot_fault[10+p]), 16'(md == 1));
        check_val(16'(prot_warn[10+p]), 16'(md == 2));
        cond[10+p] = 1'b0;
      end
    end
  endtask : mode_test

  // overload masked during start unless the start flag is set
  task automatic overload_test();
    wchk(16'h0283, 16'h0001, 1'b0);
    wchk(16'h0284, 16'h0000, 1'b0);
    starting = 1'b1;
    cond[9] = 1'b1;
    settle(3);
    check_val(16'(prot_fault[9]), 16'h0000);
    wchk(16'h0284, 16'h0001, 1'b0);
    settle(2);
    check_val(16'(prot_fault[9]), 16'h0001);
    cond[9] = 1'b0;
    starting = 1'b0;
  endtask : overload_test

  // short bursts at every tick phase never trip; a long hold does
  task automatic timed_test();
    wchk(16'h0286, 16'h0001, 1'b0);
    wchk(16'h0288, 16'h0002, 1'b0);
    repeat (5) begin
      cond[0] = 1'b1;
      settle(3);
      cond[0] = 1'b0;
      settle(2);
      check_val(16'(prot_fault[0]), 16'h0000);
    end
    cond[0] = 1'b1;
    settle(20);
    check_val(16'(prot_fault[0]), 16'h0001);
    cond[0] = 1'b0;
    settle(2);
    check_val(16'(prot_fault[0]), 16'h0000);
  endtask : timed_test

  // undervoltage counts only while the motor runs
  task automatic uv_test();
    wchk(16'h0293, 16'h0002, 1'b0);
    wchk(16'h0295, 16'h0001, 1'b0);
    cond[4] = 1'b1;
    settle(20);
    check_val(16'(prot_warn[4]), 16'h0000);
    running = 1'b1;
    settle(20);
    check_val(16'(prot_warn[4]), 16'h0001);
    cond[4] = 1'b0;
    running = 1'b0;
  endtask : uv_test

  // auto clears stop at the limit; manual clear restarts the count
  task automatic clear_test();
    wchk(16'h0280, 16'h0001, 1'b0);
    wchk(16'h0281, 16'h0001, 1'b0);
    wchk(16'h0282, 16'h0001, 1'b0);
    clr_seen = 0;
    repeat (2) begin
      motor_status = 4'b1000;
      settle(20);
      motor_status = 4'b0000;
      settle(3);
    end
    check_val(16'(clr_seen), 16'h0001);
    check_val(attempts, 16'h0001);
    wchk(16'h0280, 16'h0000, 1'b0);
    clr_seen = 0;
    manual_clear = 1'b1;
    settle(1);
    manual_clear = 1'b0;
    settle(3);
    check_val(16'(clr_seen), 16'h0001);
    check_val(attempts, 16'h0000);
  endtask : clear_test

  initial begin
    motor_status = 4'b0000;
    active_code = 16'h0000;
    starting = 1'b0;
    running = 1'b0;
    manual_clear = 1'b0;
    cond = '0;
    settle(5);
    rst_n_i = 1'b1;
    reset_vals();
    range_test();
    sel_test();
    mode_test();
    overload_test();
    timed_test();
    uv_test();
    clear_test();
    results();
  end
endmodule : sppc_regs_tb
